/* nvm_prog_pkg.sv */
// package for the nvm programming status and ecc result block
// assumes 8-bit register data and a 16-bit register address
`default_nettype none

package nvm_prog_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_PROG_CTRL = 16'h030b;
    localparam logic [15:0] ADDR_ECC_RES_FIRST = 16'h0510;
    localparam logic [15:0] ADDR_ECC_RES_LAST = 16'h0518;
    localparam logic [15:0] ADDR_PROG_STAT = 16'h0519;
    localparam logic [15:0] ADDR_IRQ_STAT = 16'h0520;
    localparam logic [15:0] ADDR_IRQ_MASK = 16'h0521;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_PAGE_BIT = 1;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ERR_BIT = 1;
    localparam int IRQ_ECC_BIT = 2;
    localparam int ECC_BYTES = 9;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] ECC_RESET = 8'h00;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // ------------------------------------------------------------
    // timing: supply stability window before the burn
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int PRECHECK_NS = 10000;
    localparam int PRECHECK_CYC = (PRECHECK_NS / CLK_PERIOD_NS) > 0 ?
        (PRECHECK_NS / CLK_PERIOD_NS) : 1;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic unlocked;
        logic overtemp_abort_flag;
        logic prog_supply_low_flag;
        logic prog_supply_high_flag;
        logic precheck_supply_low_flag;
        logic precheck_supply_high_flag;
        logic page_setting_error_flag;
        logic done;
    } prog_status_t;

    typedef struct packed {
        logic overtemp;
        logic supply_low;
        logic supply_high;
    } sense_t;

    typedef struct packed {
        logic page_attempted_flag;
        logic uv_ok;
        logic ov_ok;
    } page_state_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CHECK = 3'b010,
        ST_BURN = 3'b100
    } prog_state_t;

endpackage

`default_nettype wire

/* nvm_prog_status.sv */
// programming status, sequencing and ecc self-test result registers
// assumes sense pins are asynchronous, otp macro and coder share ref_clk
//
// Function
// - nine read-only ecc result bytes at consecutive addresses
// - decoder test fills result bytes one to eight
// - encoder test fills result bytes one to nine
// - over-temperature refuses programming and sets its error bit unless the page error bit is set
// - low supply during burn sets undervoltage error bit
// - high supply during burn sets overvoltage error bit
// - stability check before burn; low supply sets its own bit
// - stability check high supply sets its own separate bit
// - page error when locked, page attempted, or page format error
// - completion bit set when burn finishes, zero otherwise
// - start write clears supply, stability, page errors and completion
// - page format error when uv-ok or ov-ok set without attempt
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module nvm_prog_status (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // unlock code checker
    input wire logic unlock_ok,
    // analog sense pins
    input wire nvm_prog_pkg::sense_t sense_pin,
    // per-page otp state, index 0 is page 1
    input wire nvm_prog_pkg::page_state_t page_state [2],
    // otp macro
    output logic burn_en,
    output logic burn_page,
    input wire logic burn_done,
    // ecc coder
    input wire logic coder_direction_select,
    input wire logic ecc_result_valid,
    input wire logic [71:0] ecc_result,
    // interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // sense synchronisers
    // ------------------------------------------------------------
    nvm_prog_pkg::sense_t sync1_r;
    nvm_prog_pkg::sense_t sync2_r;
    nvm_prog_pkg::sense_t sync3_r;
    nvm_prog_pkg::sense_t sense_r;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end else begin
            sync1_r <= sense_pin;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // a bit moves only once two stages agree, filtering one-cycle glitches
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sense_r <= '0;
        end else begin
            sense_r <= (sync2_r & sync3_r) | (sense_r & (sync2_r | sync3_r));
        end
    end

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic wr_ctrl;
    logic start_req;
    logic [7:0] ctrl_r;
    nvm_prog_pkg::prog_status_t stat_r;
    nvm_prog_pkg::prog_state_t state_r;
    logic idle;

    assign wr_ctrl = reg_wr && (reg_addr == nvm_prog_pkg::ADDR_PROG_CTRL);
    assign idle = (state_r == nvm_prog_pkg::ST_IDLE);
    // a start while a burn is running is dropped entirely
    assign start_req = wr_ctrl && reg_wdata[nvm_prog_pkg::CTRL_START_BIT]
        && idle;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= 8'h00;
        end else if (wr_ctrl && idle) begin
            ctrl_r <= {6'h00, reg_wdata[nvm_prog_pkg::CTRL_PAGE_BIT], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // page checks
    // ------------------------------------------------------------
    logic sel_page;
    logic [1:0] fmt_err;
    logic page_bad;

    assign sel_page = reg_wdata[nvm_prog_pkg::CTRL_PAGE_BIT];

    for (genvar p = 0; p < 2; p++) begin : g_fmt
        assign fmt_err[p] = (page_state[p].uv_ok || page_state[p].ov_ok)
            && !page_state[p].page_attempted_flag;
    end

    assign page_bad = !stat_r.unlocked
        || page_state[sel_page].page_attempted_flag
        || fmt_err[sel_page];

    // ------------------------------------------------------------
    // programming sequencer
    // ------------------------------------------------------------
    logic [11:0] chk_cnt_r;
    logic go_check;
    logic chk_fail;
    logic chk_end;
    logic burn_fail;
    logic burn_end;

    assign go_check = start_req && !page_bad && !sense_r.overtemp;
    assign chk_fail = (state_r == nvm_prog_pkg::ST_CHECK)
        && (sense_r.supply_low || sense_r.supply_high);
    assign chk_end = (state_r == nvm_prog_pkg::ST_CHECK) && !chk_fail
        && (chk_cnt_r == 12'(nvm_prog_pkg::PRECHECK_CYC - 1));
    assign burn_fail = (state_r == nvm_prog_pkg::ST_BURN)
        && (sense_r.supply_low || sense_r.supply_high);
    assign burn_end = (state_r == nvm_prog_pkg::ST_BURN) && !burn_fail
        && burn_done;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= nvm_prog_pkg::ST_IDLE;
        end else begin
            unique case (state_r)
                nvm_prog_pkg::ST_IDLE: begin
                    if (go_check) begin
                        state_r <= nvm_prog_pkg::ST_CHECK;
                    end
                end
                nvm_prog_pkg::ST_CHECK: begin
                    if (chk_fail) begin
                        state_r <= nvm_prog_pkg::ST_IDLE;
                    end else if (chk_end) begin
                        state_r <= nvm_prog_pkg::ST_BURN;
                    end
                end
                nvm_prog_pkg::ST_BURN: begin
                    if (burn_fail || burn_end) begin
                        state_r <= nvm_prog_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= nvm_prog_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            chk_cnt_r <= 12'h000;
        end else if (state_r == nvm_prog_pkg::ST_CHECK) begin
            chk_cnt_r <= chk_cnt_r + 12'h001;
        end else begin
            chk_cnt_r <= 12'h000;
        end
    end

    assign burn_en = (state_r == nvm_prog_pkg::ST_BURN);
    assign burn_page = ctrl_r[nvm_prog_pkg::CTRL_PAGE_BIT];

    // ------------------------------------------------------------
    // status register
    // ------------------------------------------------------------
    // unlock set wins over a relocking write in the same cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stat_r.unlocked <= 1'b0;
        end else if (unlock_ok) begin
            stat_r.unlocked <= 1'b1;
        end else if (reg_wr && !wr_ctrl) begin
            stat_r.unlocked <= 1'b0;
        end
    end

    // flags only change on a start or on a sequencer event, so set and
    // clear never meet in one cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stat_r[6:0] <= nvm_prog_pkg::STAT_RESET[6:0];
        end else if (start_req) begin
            stat_r.overtemp_abort_flag <= !page_bad && sense_r.overtemp;
            stat_r.prog_supply_low_flag <= 1'b0;
            stat_r.prog_supply_high_flag <= 1'b0;
            stat_r.precheck_supply_low_flag <= 1'b0;
            stat_r.precheck_supply_high_flag <= 1'b0;
            stat_r.page_setting_error_flag <= page_bad;
            stat_r.done <= 1'b0;
        end else begin
            if (chk_fail) begin
                stat_r.precheck_supply_low_flag <= sense_r.supply_low;
                stat_r.precheck_supply_high_flag <= sense_r.supply_high;
            end
            if (burn_fail) begin
                stat_r.prog_supply_low_flag <= sense_r.supply_low;
                stat_r.prog_supply_high_flag <= sense_r.supply_high;
            end
            if (burn_end) begin
                stat_r.done <= 1'b1;
            end
        end
    end
    // over-temperature is checked after page errors, so a bad page never
    // reports both flags

    // ------------------------------------------------------------
    // ecc result bytes
    // ------------------------------------------------------------
    logic [7:0] ecc_r [nvm_prog_pkg::ECC_BYTES];

    for (genvar b = 0; b < nvm_prog_pkg::ECC_BYTES; b++) begin : g_ecc
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                ecc_r[b] <= nvm_prog_pkg::ECC_RESET;
            end else if (ecc_result_valid) begin
                if (b == nvm_prog_pkg::ECC_BYTES - 1
                    && !coder_direction_select) begin
                    ecc_r[b] <= nvm_prog_pkg::ECC_RESET;
                end else begin
                    ecc_r[b] <= ecc_result[b*8 +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    logic [2:0] irq_stat_r;
    logic [2:0] irq_mask_r;
    logic [2:0] irq_ev;
    logic [2:0] irq_clr;
    logic wr_istat;

    assign irq_ev = {ecc_result_valid,
        start_req && (page_bad || sense_r.overtemp) || chk_fail || burn_fail,
        burn_end};
    assign wr_istat = reg_wr && (reg_addr == nvm_prog_pkg::ADDR_IRQ_STAT);
    assign irq_clr = wr_istat ? reg_wdata[2:0] : 3'h0;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_stat_r <= nvm_prog_pkg::IRQ_RESET;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_mask_r <= nvm_prog_pkg::IRQ_RESET;
        end else if (reg_wr && reg_addr == nvm_prog_pkg::ADDR_IRQ_MASK) begin
            irq_mask_r <= reg_wdata[2:0];
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    logic [7:0] rd_nxt;
    logic [15:0] ecc_idx;

    assign ecc_idx = reg_addr - nvm_prog_pkg::ADDR_ECC_RES_FIRST;

    always_comb begin
        rd_nxt = 8'h00;
        if (reg_addr >= nvm_prog_pkg::ADDR_ECC_RES_FIRST
            && reg_addr <= nvm_prog_pkg::ADDR_ECC_RES_LAST) begin
            rd_nxt = ecc_r[ecc_idx[3:0]];
        end else if (reg_addr == nvm_prog_pkg::ADDR_PROG_STAT) begin
            rd_nxt = stat_r;
        end else if (reg_addr == nvm_prog_pkg::ADDR_PROG_CTRL) begin
            rd_nxt = ctrl_r;
        end else if (reg_addr == nvm_prog_pkg::ADDR_IRQ_STAT) begin
            rd_nxt = {5'h00, irq_stat_r};
        end else if (reg_addr == nvm_prog_pkg::ADDR_IRQ_MASK) begin
            rd_nxt = {5'h00, irq_mask_r};
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_nxt : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_start_clears: assert property (
        start_req |=> !stat_r.done && !stat_r.prog_supply_low_flag
            && !stat_r.precheck_supply_high_flag)
        else $error("start did not clear status");

    a_page_error: assert property (
        start_req && !stat_r.unlocked |=> stat_r.page_setting_error_flag
            && state_r == nvm_prog_pkg::ST_IDLE)
        else $error("locked start not refused");

    a_overtemp_refuse: assert property (
        start_req && !page_bad && sense_r.overtemp
            |=> stat_r.overtemp_abort_flag && idle ##1 !burn_en [*2])
        else $error("overtemp start not refused");

    a_precheck_low: assert property (
        chk_fail && sense_r.supply_low
            |=> stat_r.precheck_supply_low_flag && idle)
        else $error("precheck low not flagged");

    a_burn_high: assert property (
        burn_fail && sense_r.supply_high
            |=> stat_r.prog_supply_high_flag && !burn_en)
        else $error("burn high not flagged");

    a_done_set: assert property (
        burn_end |=> stat_r.done && idle)
        else $error("done not set after burn");

    a_done_hold: assert property (
        stat_r.done && !start_req |=> stat_r.done)
        else $error("done dropped without start");

    a_relock: assert property (
        reg_wr && !wr_ctrl && !unlock_ok |=> !stat_r.unlocked)
        else $error("write did not relock");

    a_ecc_decoder: assert property (
        ecc_result_valid && !coder_direction_select
            |=> ecc_r[8] == 8'h00 && ecc_r[0] == $past(ecc_result[7:0]))
        else $error("decoder result misplaced");

    a_burn_entry: assert property (
        go_check |=> !burn_en [*2])
        else $error("burn began without precheck");

    c_burn_ok: cover property (chk_end ##[1:300] burn_end);
    c_precheck_fail: cover property (chk_fail);
    c_page_err: cover property (start_req && page_bad);
    c_ecc_enc: cover property (ecc_result_valid && coder_direction_select);

endmodule

`default_nettype wire

/* nvm_macro_model.sv */
// behavioural model of the otp macro behind the burn handshake
// assumes burn_en is a level from the status block on ref_clk
`timescale 1ns/1ps
`default_nettype none

module nvm_macro_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // burn handshake
    input wire logic burn_en,
    output logic burn_done,
    // answer delay in cycles, zero stalls forever
    input wire logic [11:0] done_delay
);
    // ------------------------------------------------------------
    // burn timer
    // ------------------------------------------------------------
    logic [11:0] cnt_r;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= 12'h000;
        end else if (!burn_en) begin
            cnt_r <= 12'h000;
        end else if (cnt_r != 12'hfff) begin
            cnt_r <= cnt_r + 12'h001;
        end
    end

    // done drops with burn_en, so a stale answer never lingers
    assign burn_done = burn_en && (done_delay != 12'h000) &&
        (cnt_r == done_delay);
endmodule
`default_nettype wire

/* otp_program_status_ecc_result_tb.sv */
// testbench for the nvm programming status and ecc result block
// assumes the macro model answers burns; unlock_ok stands for code entry
`timescale 1ns/1ps
`default_nettype none

module otp_program_status_ecc_result_tb;
    logic ref_clk;
    logic nrst;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic unlock_ok;
    nvm_prog_pkg::sense_t sense;
    nvm_prog_pkg::page_state_t page_st [2];
    logic burn_en;
    logic burn_page;
    logic burn_done;
    logic coder_dir;
    logic ecc_valid;
    logic [71:0] ecc_data;
    logic irq;
    logic [11:0] done_delay;
    logic [7:0] got;
    logic [2:0] pcase [3];
    int mismatches;
    int checks_done;

    nvm_prog_status dut (
        .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .unlock_ok(unlock_ok), .sense_pin(sense),
        .page_state(page_st), .burn_en(burn_en), .burn_page(burn_page),
        .burn_done(burn_done), .coder_direction_select(coder_dir),
        .ecc_result_valid(ecc_valid), .ecc_result(ecc_data), .irq(irq)
    );

    nvm_macro_model macro (
        .ref_clk(ref_clk), .nrst(nrst), .burn_en(burn_en),
        .burn_done(burn_done), .done_delay(done_delay)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // host tasks
    // ------------------------------------------------------------
    task automatic conclude();
        if (mismatches == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e,
            input logic [7:0] m);
        checks_done++;
        if ((g & m) !== (e & m)) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask

    task automatic chk_bit(input logic g, input logic e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: flag %b want %b", $time, g, e);
        end
    endtask

    // trailing #1 lets the accepting edge land before any compare
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic stat(input logic [7:0] e, input logic [7:0] m);
        rd(nvm_prog_pkg::ADDR_PROG_STAT, got);
        chk(got, e, m);
    endtask

    task automatic unlock();
        @(posedge ref_clk);
        unlock_ok <= 1'b1;
        @(posedge ref_clk);
        unlock_ok <= 1'b0;
    endtask

    task automatic start(input logic page);
        wr(nvm_prog_pkg::ADDR_PROG_CTRL, page ? 8'h03 : 8'h01);
        repeat (2) @(posedge ref_clk);
    endtask

    // sense pins pass a filter, so allow several edges to take hold
    task automatic sense_set(input logic [2:0] v);
        @(posedge ref_clk);
        sense <= v;
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic ecc_run(input logic dir, input logic [71:0] d);
        @(posedge ref_clk);
        coder_dir <= dir;
        ecc_data <= d;
        ecc_valid <= 1'b1;
        @(posedge ref_clk);
        ecc_valid <= 1'b0;
        #1;
    endtask

    task automatic wait_burn(input logic lvl);
        int n;
        n = 0;
        while (burn_en !== lvl) begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n > 4000) begin
                mismatches++;
                $display("mismatch at %0t: burn wait ran out", $time);
                conclude();
            end
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        unlock_ok = 1'b0;
        sense = 3'h0;
        page_st[0] = 3'h0;
        page_st[1] = 3'h0;
        coder_dir = 1'b0;
        ecc_valid = 1'b0;
        ecc_data = 72'h0;
        done_delay = 12'h010;
        pcase = '{3'h4, 3'h2, 3'h1};
        mismatches = 0;
        checks_done = 0;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        for (int k = 0; k < 10; k++) begin
            rd(nvm_prog_pkg::ADDR_ECC_RES_FIRST + 16'(k), got);
            chk(got, 8'h00, 8'hff);
        end
        rd(16'h0600, got);
        chk(got, 8'h00, 8'hff);
        wr(nvm_prog_pkg::ADDR_IRQ_MASK, 8'h07);
        ecc_run(1'b1, 72'h998877665544332211);
        chk_bit(irq, 1'b1);
        for (int k = 0; k < 9; k++) begin
            rd(nvm_prog_pkg::ADDR_ECC_RES_FIRST + 16'(k), got);
            chk(got, 8'(8'h11 * (k + 1)), 8'hff);
        end
        ecc_run(1'b0, ~72'h998877665544332211);
        for (int k = 0; k < 9; k++) begin
            rd(nvm_prog_pkg::ADDR_ECC_RES_FIRST + 16'(k), got);
            chk(got, k == 8 ? 8'h00 : ~8'(8'h11 * (k + 1)), 8'hff);
        end
        wr(nvm_prog_pkg::ADDR_ECC_RES_FIRST, 8'h5a);
        rd(nvm_prog_pkg::ADDR_ECC_RES_FIRST, got);
        chk(got, 8'hee, 8'hff);
        wr(nvm_prog_pkg::ADDR_IRQ_STAT, 8'h07);
        chk_bit(irq, 1'b0);
        start(1'b0);
        stat(8'h02, 8'hff);
        unlock();
        stat(8'h82, 8'hff);
        wr(nvm_prog_pkg::ADDR_IRQ_STAT, 8'h07);
        stat(8'h02, 8'hff);
        for (int c = 0; c < 3; c++) begin
            @(posedge ref_clk);
            page_st[c == 0] <= pcase[c];
            unlock();
            start(c == 0);
            stat(8'h02, 8'h7f);
            chk_bit(burn_en, 1'b0);
            @(posedge ref_clk);
            page_st[c == 0] <= 3'h0;
        end
        sense_set(3'h4);
        unlock();
        start(1'b0);
        stat(8'h40, 8'h7f);
        chk_bit(burn_en, 1'b0);
        sense_set(3'h0);
        // low then high supply while the stability check runs
        for (int c = 0; c < 2; c++) begin
            unlock();
            start(1'b0);
            repeat (20) @(posedge ref_clk);
            sense_set(c == 0 ? 3'h2 : 3'h1);
            stat(c == 0 ? 8'h08 : 8'h04, 8'h7f);
            chk_bit(burn_en, 1'b0);
            sense_set(3'h0);
        end
        // macro stalls so the supply fault lands mid-burn
        done_delay <= 12'h000;
        for (int c = 0; c < 2; c++) begin
            unlock();
            start(1'b1);
            wait_burn(1'b1);
            chk_bit(burn_page, 1'b1);
            sense_set(c == 0 ? 3'h2 : 3'h1);
            stat(c == 0 ? 8'h20 : 8'h10, 8'h7f);
            chk_bit(burn_en, 1'b0);
            sense_set(3'h0);
        end
        // the irq clear write also relocks, so this start is refused as locked
        wr(nvm_prog_pkg::ADDR_IRQ_STAT, 8'h07);
        start(1'b0);
        stat(8'h02, 8'hff);
        repeat (50) @(posedge ref_clk);
        stat(8'h02, 8'hff);
        wr(nvm_prog_pkg::ADDR_IRQ_STAT, 8'h07);
        done_delay <= 12'h010;
        unlock();
        start(1'b0);
        wait_burn(1'b1);
        chk_bit(burn_page, 1'b0);
        stat(8'h00, 8'h7f);
        wait_burn(1'b0);
        stat(8'h01, 8'h7f);
        chk_bit(irq, 1'b1);
        wr(nvm_prog_pkg::ADDR_IRQ_MASK, 8'h00);
        chk_bit(irq, 1'b0);
        wr(nvm_prog_pkg::ADDR_IRQ_MASK, 8'h07);
        chk_bit(irq, 1'b1);
        wr(nvm_prog_pkg::ADDR_IRQ_STAT, 8'h01);
        chk_bit(irq, 1'b0);
        stat(8'h01, 8'hff);
        conclude();
    end
endmodule
`default_nettype wire
